// >>> twowire_slave_pointer_port.sv
`timescale 1ns/1ps
`default_nettype none
module twowire_slave_pointer_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [7:0] measured_temp,
    input wire logic [7:0] alarm_limit,
    output logic overtemp_alarm_pin_out,
    output logic overtemp_alarm_pin_oe_n,
    output logic [7:0] hysteresis_degrees_field
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_IGNORE
    } port_state_t;

    port_state_t state_reg;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic sda_low_reg;
    logic rw_reg;
    logic have_ptr_reg;
    logic master_ack_reg;
    logic [7:0] pointer_reg;
    logic [7:0] hyst_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] read_value;

    alarm_if alm ();

    // byte returned for a given pointer
    function automatic logic [7:0] reg_read(input logic [7:0] ptr,
                                            input logic [7:0] hyst);
        if (ptr == twowire_slave_pkg::HYST_PTR)
            return hyst;
        return twowire_slave_pkg::UNMAPPED_READ;
    endfunction

    // pins are synchronous; one stage of history for edges
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // bus events; data moving under a high clock is never data
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_det = scl_in && scl_q && sda_q && !sda_in;
    assign stop_det = scl_in && scl_q && !sda_q && sda_in;
    assign read_value = reg_read(pointer_reg, hyst_reg);

    // transfer sequencing, shift and drive
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= twowire_slave_pkg::BIT_CNT_RESET;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sda_low_reg <= 1'b0;
            rw_reg <= twowire_slave_pkg::DIR_WRITE;
            have_ptr_reg <= 1'b0;
            master_ack_reg <= 1'b0;
        end
        else if (start_det)
        begin
            // a restart aborts whatever was running
            state_reg <= ST_ADDR;
            bit_cnt_reg <= twowire_slave_pkg::BIT_CNT_RESET;
            sda_low_reg <= 1'b0;
            have_ptr_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= ST_IDLE;
            sda_low_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE:
                begin
                    sda_low_reg <= 1'b0;
                end
                ST_ADDR, ST_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall
                             && bit_cnt_reg == twowire_slave_pkg::BYTE_BITS)
                    begin
                        if (state_reg == ST_WR_BYTE)
                        begin
                            // every written byte is acknowledged
                            sda_low_reg <= 1'b1;
                            state_reg <= ST_WR_ACK;
                        end
                        else if (shift_reg[7:1] ==
                                 twowire_slave_pkg::SLAVE_ADDR)
                        begin
                            sda_low_reg <= 1'b1;
                            rw_reg <= shift_reg[0];
                            state_reg <= ST_ADDR_ACK;
                        end
                        else
                        begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    // ack held through the high phase; on the fall, let go for a write, replaced by the first bit for a read
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= twowire_slave_pkg::BIT_CNT_RESET;
                        if (rw_reg == twowire_slave_pkg::DIR_READ)
                        begin
                            tx_reg <= read_value;
                            sda_low_reg <= !read_value[7];
                            state_reg <= ST_RD_BYTE;
                        end
                        else
                        begin
                            sda_low_reg <= 1'b0;
                            state_reg <= ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_low_reg <= 1'b0;
                        bit_cnt_reg <= twowire_slave_pkg::BIT_CNT_RESET;
                        have_ptr_reg <= 1'b1;
                        state_reg <= ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_reg == twowire_slave_pkg::BYTE_BITS)
                        begin
                            // master owns the ack clock
                            sda_low_reg <= 1'b0;
                            master_ack_reg <= 1'b0;
                            state_reg <= ST_RD_ACK;
                        end
                        else
                        begin
                            // next bit only while clock is low
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_low_reg <= !tx_reg[6];
                        end
                    end
                end
                ST_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        master_ack_reg <= !sda_in;
                    end
                    else if (scl_fall)
                    begin
                        if (master_ack_reg)
                        begin
                            // single-byte register: repeat it
                            bit_cnt_reg <= twowire_slave_pkg::BIT_CNT_RESET;
                            tx_reg <= read_value;
                            sda_low_reg <= !read_value[7];
                            state_reg <= ST_RD_BYTE;
                        end
                        else
                        begin
                            sda_low_reg <= 1'b0;
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    // pointer and hysteresis writes, taken at the end of each byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pointer_reg <= twowire_slave_pkg::PTR_RESET;
            hyst_reg <= twowire_slave_pkg::HYST_RESET;
        end
        else if (!start_det && !stop_det && state_reg == ST_WR_BYTE
                 && scl_fall && bit_cnt_reg == twowire_slave_pkg::BYTE_BITS)
        begin
            if (!have_ptr_reg)
            begin
                pointer_reg <= shift_reg;
            end
            else if (pointer_reg == twowire_slave_pkg::HYST_PTR)
            begin
                hyst_reg <= shift_reg;
            end
        end
    end

    // open-drain pins: only ever pull low; there is no clock output
    assign sda_out = 1'b0;
    assign sda_oe_n = !sda_low_reg;
    assign alm.hysteresis = hyst_reg;
    assign hysteresis_degrees_field = hyst_reg;
    assign overtemp_alarm_pin_out = 1'b0;
    assign overtemp_alarm_pin_oe_n = !alm.alarm;

    overtemp_hysteresis u_overtemp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .measured_temp(measured_temp),
        .alarm_limit(alarm_limit),
        .alm(alm.comparator)
    );

    addr_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_ADDR && scl_fall && !start_det && !stop_det
        && bit_cnt_reg == 4'h8 && shift_reg[7:1] == 7'h4c)
        |=> sda_low_reg && state_reg == ST_ADDR_ACK)
        else $error("matching address not acknowledged");
    no_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_IGNORE) |=> !sda_low_reg)
        else $error("data driven after address mismatch");
    stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_det |=> state_reg == ST_IDLE && sda_oe_n)
        else $error("stop did not release the bus");
    start_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
        else $error("start not recognised");
    sda_stable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (scl_q && scl_in) |=> $stable(sda_low_reg))
        else $error("data moved while clock high");
    ptr_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_WR_BYTE && scl_fall && !start_det && !stop_det
        && bit_cnt_reg == 4'h8 && !have_ptr_reg)
        |=> pointer_reg == $past(shift_reg))
        else $error("pointer not loaded from first byte");
    hyst_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_WR_BYTE && scl_fall && !start_det && !stop_det
        && bit_cnt_reg == 4'h8 && have_ptr_reg && pointer_reg == 8'h21)
        |=> hyst_reg == $past(shift_reg))
        else $error("hysteresis write lost");
    nack_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_RD_ACK && scl_fall && !master_ack_reg
        && !start_det && !stop_det)
        |=> state_reg == ST_IGNORE ##1 sda_oe_n)
        else $error("data not released after not-acknowledge");
    read_msb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_ADDR_ACK && scl_fall && rw_reg && !start_det
        && !stop_det) |=> sda_low_reg == !$past(read_value[7]))
        else $error("read did not start with the msb");
    ptr_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_RD_BYTE) |=> $stable(pointer_reg))
        else $error("pointer changed during a read");

    cover_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_WR_ACK && have_ptr_reg);
    cover_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_RD_ACK ##1 state_reg == ST_RD_BYTE);
    cover_nomatch: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_ADDR ##1 state_reg == ST_IGNORE);
endmodule
`default_nettype wire

// >>> twowire_slave_pkg.sv
`default_nettype none
package twowire_slave_pkg;
    // bus address of this slave, seven bits
    localparam logic [6:0] SLAVE_ADDR = 7'h4c;
    // register index and power-on value of the hysteresis register
    localparam logic [7:0] HYST_PTR = 8'h21;
    localparam logic [7:0] HYST_RESET = 8'h0a;
    // pointer value after power-on
    localparam logic [7:0] PTR_RESET = 8'h00;
    // value returned for an index that holds no register here
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // clock rises per byte before the acknowledge clock
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    // direction bit values
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
endpackage
`default_nettype wire

// >>> alarm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface alarm_if;
    logic [7:0] hysteresis;
    logic alarm;
    modport owner (output hysteresis, input alarm);
    modport comparator (input hysteresis, output alarm);
endinterface
`default_nettype wire

// >>> overtemp_hysteresis.sv
`timescale 1ns/1ps
`default_nettype none
module overtemp_hysteresis (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] measured_temp,
    input wire logic [7:0] alarm_limit,
    alarm_if.comparator alm
);
    logic alarm_reg;
    logic alarm_next;
    logic [8:0] release_level;

    // limit minus hysteresis may go negative: then it never releases
    assign release_level = {1'b0, alarm_limit} - {1'b0, alm.hysteresis};

    // set at the limit, release only below limit minus hysteresis
    always_comb
    begin
        alarm_next = alarm_reg;
        if (measured_temp >= alarm_limit)
        begin
            alarm_next = 1'b1;
        end
        else if (!release_level[8] && measured_temp < release_level[7:0])
        begin
            alarm_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_reg <= 1'b0;
        end
        else
        begin
            alarm_reg <= alarm_next;
        end
    end

    assign alm.alarm = alarm_reg;

    hold_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (alarm_reg && (release_level[8]
        || measured_temp >= release_level[7:0])) |=> alarm_reg)
        else $error("alarm released inside the hysteresis band");
    trip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (measured_temp >= alarm_limit) |=> alarm_reg)
        else $error("alarm not raised at the limit");
    cover_release: cover property (@(posedge ref_clk) disable iff (!rst_n)
        alarm_reg ##1 !alarm_reg);
endmodule
`default_nettype wire

// >>> twowire_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module twowire_master_model (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // both lines released at power-up: bus idle
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // every change lands just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one bus clock; data moves only while the clock is low
    task automatic bit_cycle(input logic b, output logic s);
        tick(2);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(3);
        s = sda;
        tick(3);
        scl = 1'b0;
    endtask
    // also serves as a repeated start when the clock is low
    task automatic start_cond;
        sda_m = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop_cond;
        sda_m = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask
    // eight bits msb first, then the ack clock with the line released
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(d[i], s);
        bit_cycle(1'b1, ack);
    endtask
    // last byte of a read is refused so the slave lets go
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, d[i]);
        bit_cycle(nack, s);
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [6:0] ME = twowire_slave_pkg::SLAVE_ADDR;
    localparam logic [7:0] PH = twowire_slave_pkg::HYST_PTR;
    localparam logic [7:0] TTAB [4] = '{8'h50, 8'h4b, 8'h4a, 8'h4f};
    logic ref_clk, rst_n, scl, sda_m, sda, sda_out, sda_oe_n;
    logic alarm_out, alarm_oe_n, prev_scl, prev_oe_n, alarm_st;
    logic [7:0] measured_temp, alarm_limit, hyst, hyst_exp, ptr_exp, d, t;
    logic [6:0] a;
    int n_mismatch, tests_run;
    // open-drain data wire with pull-up
    assign sda = sda_m & (sda_oe_n ? 1'b1 : sda_out);
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    twowire_master_model master (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_m(sda_m));
    twowire_slave_pointer_port DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .measured_temp(measured_temp), .alarm_limit(alarm_limit),
        .overtemp_alarm_pin_out(alarm_out),
        .overtemp_alarm_pin_oe_n(alarm_oe_n),
        .hysteresis_degrees_field(hyst));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] exp_read(input logic [7:0] p, h);
        return (p === PH) ? h : twowire_slave_pkg::UNMAPPED_READ;
    endfunction
    // alarm sets at the limit, releases only below limit minus hysteresis
    function automatic logic exp_alarm(input logic st, input logic [7:0] tt,
        input logic [7:0] l, input logic [7:0] h);
        if (tt >= l)
            return 1'b1;
        if (int'(tt) < int'(l) - int'(h))
            return 1'b0;
        return st;
    endfunction
    // the device may move the data line only while the clock is low
    always @(posedge ref_clk)
    begin
        if (rst_n && scl && prev_scl && sda_oe_n !== prev_oe_n)
            check(8'h01, 8'h00);
        if (!sda_oe_n && sda_out !== 1'b0)
            check(8'h01, 8'h00);
        prev_scl <= scl;
        prev_oe_n <= sda_oe_n;
    end
    task automatic wbyte(input logic [7:0] v, input logic exp_nack);
        logic k;
        master.write_byte(v, k);
        check({7'h0, k}, {7'h0, exp_nack});
    endtask
    task automatic fin;
        master.stop_cond();
        check({7'h0, sda_oe_n}, 8'h01);
    endtask
    // write: address, pointer, then nd data bytes; restart skips the stop
    task automatic wr(input logic [6:0] ad, input logic [7:0] p, input int nd,
        input logic [7:0] v, input logic restart);
        logic miss;
        miss = (ad != ME);
        master.start_cond();
        wbyte({ad, twowire_slave_pkg::DIR_WRITE}, miss);
        wbyte(p, miss);
        repeat (nd) wbyte(v, miss);
        if (!miss)
            ptr_exp = p;
        if (!miss && p == PH && nd > 0)
            hyst_exp = v;
        if (!restart)
            fin();
        check(hyst, hyst_exp);
    endtask
    // read n bytes from the stored pointer, last byte refused
    task automatic rd(input int n);
        logic [7:0] r;
        master.start_cond();
        wbyte({ME, twowire_slave_pkg::DIR_READ}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            master.read_byte(i == n - 1, r);
            check(r, exp_read(ptr_exp, hyst_exp));
        end
        fin();
    endtask
    initial
    begin
        rst_n = 1'b0;
        measured_temp = 8'h00;
        alarm_limit = 8'h50;
        n_mismatch = 0;
        tests_run = 0;
        prev_scl = 1'b1;
        prev_oe_n = 1'b1;
        alarm_st = 1'b0;
        hyst_exp = twowire_slave_pkg::HYST_RESET;
        ptr_exp = twowire_slave_pkg::PTR_RESET;
        d = 8'($urandom(82));
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        master.tick(2);
        check(hyst, twowire_slave_pkg::HYST_RESET);
        check({7'h0, sda_oe_n}, 8'h01);
        check({7'h0, alarm_oe_n}, 8'h01);
        rd(1);
        $display("test power-on done");
        // full scale, other index, zero, pointer-only write then restart
        wr(ME, PH, 1, 8'hff, 1'b0);
        rd(2);
        wr(ME, 8'h22, 2, 8'h33, 1'b0);
        rd(1);
        wr(ME, PH, 1, 8'h00, 1'b0);
        wr(ME, PH, 0, 8'h00, 1'b1);
        rd(3);
        wr(7'h4d, PH, 1, 8'h77, 1'b0);
        $display("test corners done");
        repeat (8)
        begin
            a = $urandom_range(1) ? ME : 7'($urandom);
            d = 8'($urandom);
            wr(a, $urandom_range(1) ? PH : 8'($urandom), $urandom_range(2), d,
                1'($urandom_range(1)));
            rd(1 + $urandom_range(2));
        end
        $display("test random traffic done");
        // hysteresis 5 against limit 50h: exact edges first, then random
        wr(ME, PH, 1, 8'h05, 1'b0);
        for (int i = 0; i < 12; i++)
        begin
            t = (i < 4) ? TTAB[i] : 8'(8'h44 + $urandom_range(15));
            measured_temp = t;
            master.tick(4);
            alarm_st = exp_alarm(alarm_st, t, alarm_limit, hyst_exp);
            check({7'h0, alarm_oe_n}, {7'h0, ~alarm_st});
            check({7'h0, alarm_out}, 8'h00);
        end
        $display("test alarm done");
        // reset in mid-run restores the power-on state
        rst_n = 1'b0;
        master.tick(1);
        check(hyst, twowire_slave_pkg::HYST_RESET);
        rst_n = 1'b1;
        hyst_exp = twowire_slave_pkg::HYST_RESET;
        ptr_exp = twowire_slave_pkg::PTR_RESET;
        master.tick(2);
        rd(1);
        $display("test second reset done");
        tally_and_finish();
    end
    // whole run needs some 10000 cycles; allow six times that
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
